/* File: include/basic_watchdog_consts.svh */
// Constants for the basic watchdog: offsets, field positions, reset values.
// Assumes inclusion by bare name from every file that needs them.
`ifndef BASIC_WATCHDOG_CONSTS_SVH
`define BASIC_WATCHDOG_CONSTS_SVH

`define WDG_ADDR_W       8
`define WDG_DATA_W       32
`define WDG_DIV_W        16
`define WDG_IRQ_W        3

`define OFS_CTRL         8'h00
`define OFS_EXPIRE       8'h04
`define OFS_DEFER        8'h08
`define OFS_COUNT        8'h0C
`define OFS_STATUS       8'h10
`define OFS_IRQ_STATUS   8'h14
`define OFS_IRQ_MASK     8'h18
`define OFS_TICK_DIV     8'h1C

`define CTRL_EN_BIT      0
`define CTRL_SRC_BIT     1
`define CTRL_TAMP_BIT    2

`define STAT_EN_BIT      0
`define STAT_ATTN_BIT    1
`define STAT_TAMP_BIT    2
`define STAT_STATE_LSB   4
`define STAT_STATE_MSB   5

`define IRQ_EXP_BIT      0
`define IRQ_TAMP_BIT     1
`define IRQ_INIT_BIT     2

`define DEF_ENABLE       1'b0
`define DEF_EXPIRE       32'h0001_0000
`define DEF_DIV          16'h007C
`define DEF_TAMP_EN      1'b1
`define ZERO_COUNT       32'h0000_0000
`define ONE_COUNT        32'h0000_0001
`define ZERO_WORD        32'h0000_0000
`define ZERO_DIV         16'h0000
`define ONE_DIV          16'h0001
`define ZERO_IRQ         3'h0

`endif

/* File: include/basic_watchdog_pkg.sv */
// Types shared by the watchdog modules.
// Assumes the constants header is compiled alongside.
package basic_watchdog_pkg;
    typedef enum logic [1:0] {ST_DISABLED, ST_COUNTING, ST_EXPIRED} wdg_state_t;
    typedef enum logic {SRC_TICK, SRC_EVENT} src_sel_t;
endpackage

/* File: include/wdog_src_if.sv */
// Carrier between the watchdog core and its count source.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "basic_watchdog_consts.svh"
interface wdog_src_if;
    import basic_watchdog_pkg::*;
    logic [`WDG_DIV_W-1:0] div;
    src_sel_t              sel;
    logic                  run;
    logic                  restart;
    logic                  step;
    modport ctrl (output div, output sel, output run, output restart, input step);
    modport src  (input div, input sel, input run, input restart, output step);
endinterface
`default_nettype wire

/* File: hw/count_source.sv */
// Count source: internal tick prescaler or external event edges.
// Assumes i_event is synchronous to i_clk.
`timescale 1ns/1ns
`default_nettype none
`include "basic_watchdog_consts.svh"
module count_source (
    input  wire logic  i_clk,
    input  wire logic  i_resetn,
    input  wire logic  i_event,
    wdog_src_if.src    src
);
    import basic_watchdog_pkg::*;

    logic [`WDG_DIV_W-1:0] pre_r;
    logic [`WDG_DIV_W-1:0] pre_nxt;
    logic                  ev_prev_r;
    logic                  step_r;
    logic                  step_nxt;
    wire                   tick_due = (pre_r >= src.div);
    wire                   ev_rise  = i_event & ~ev_prev_r;
    wire                   use_tick = (src.sel == SRC_TICK);

    // Restart realigns the prescaler so a deferral grants a full tick
    assign pre_nxt  = (src.restart | ~src.run | tick_due) ? `ZERO_DIV
                                                          : pre_r + `ONE_DIV;
    assign step_nxt = src.run & ~src.restart & (use_tick ? tick_due : ev_rise);
    assign src.step = step_r;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pre_r     <= `ZERO_DIV;
            ev_prev_r <= 1'b0;
            step_r    <= 1'b0;
        end else begin
            pre_r     <= pre_nxt;
            ev_prev_r <= i_event;
            step_r    <= step_nxt;
        end
    end
endmodule
`default_nettype wire

/* File: hw/sticky_irq.sv */
// Sticky interrupt status with write-one-to-clear and a mask.
// Assumes set and clear arrive as one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
`include "basic_watchdog_consts.svh"
module sticky_irq (
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    input  wire logic [`WDG_IRQ_W-1:0] i_set,
    input  wire logic [`WDG_IRQ_W-1:0] i_clr,
    input  wire logic                  i_mask_we,
    input  wire logic [`WDG_IRQ_W-1:0] i_mask_wdata,
    output logic      [`WDG_IRQ_W-1:0] o_status,
    output logic      [`WDG_IRQ_W-1:0] o_mask,
    output logic                       o_irq
);
    logic [`WDG_IRQ_W-1:0] status_r;
    logic [`WDG_IRQ_W-1:0] mask_r;

    // Set wins over a clear in the same cycle
    wire [`WDG_IRQ_W-1:0] status_nxt = (status_r & ~i_clr) | i_set;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            status_r <= `ZERO_IRQ;
            mask_r   <= `ZERO_IRQ;
        end else begin
            status_r <= status_nxt;
            if (i_mask_we) begin
                mask_r <= i_mask_wdata;
            end
        end
    end

    assign o_status = status_r;
    assign o_mask   = mask_r;
    assign o_irq    = |(status_r & mask_r);
endmodule
`default_nettype wire

/* File: hw/basic_watchdog.sv */
// Basic watchdog counter core with register port and attention output.
// Assumes all inputs synchronous to i_clk; i_init is a trusted source.
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "basic_watchdog_consts.svh"
module basic_watchdog (
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    input  wire logic [`WDG_ADDR_W-1:0] i_addr,
    input  wire logic [`WDG_DATA_W-1:0] i_wdata,
    input  wire logic                  i_we,
    input  wire logic                  i_re,
    output logic      [`WDG_DATA_W-1:0] o_rdata,
    input  wire logic                  i_init,
    input  wire logic                  i_event,
    input  wire logic                  i_tamper,
    output logic                       o_attention,
    output logic                       o_irq
);
    import basic_watchdog_pkg::*;

    function automatic logic addr_is(input logic [`WDG_ADDR_W-1:0] a,
                                     input logic [`WDG_ADDR_W-1:0] ofs);
        addr_is = (a == ofs);
    endfunction

    function automatic logic reached(input logic [`WDG_DATA_W-1:0] cnt,
                                     input logic [`WDG_DATA_W-1:0] lim);
        // Greater-or-equal so a lowered limit still expires
        reached = (cnt >= lim);
    endfunction

    wdog_src_if src_bus ();

    // Register state
    wdg_state_t            state_r;
    wdg_state_t            state_nxt;
    logic [`WDG_DATA_W-1:0] count_r;
    logic [`WDG_DATA_W-1:0] count_nxt;
    logic [`WDG_DATA_W-1:0] expire_r;
    logic [`WDG_DATA_W-1:0] expire_nxt;
    src_sel_t              src_sel_r;
    src_sel_t              src_sel_nxt;
    logic                  tamp_en_r;
    logic                  tamp_en_nxt;
    logic                  tamper_r;
    logic                  tamper_nxt;
    logic [`WDG_DIV_W-1:0]  div_r;
    logic [`WDG_DIV_W-1:0]  div_nxt;
    logic [`WDG_DATA_W-1:0] rdata_r;
    logic [`WDG_DATA_W-1:0] rdata_nxt;

    // Address decode
    wire wr_ctrl    = i_we & addr_is(i_addr, `OFS_CTRL);
    wire wr_expire  = i_we & addr_is(i_addr, `OFS_EXPIRE);
    wire wr_defer   = i_we & addr_is(i_addr, `OFS_DEFER);
    wire wr_irq_st  = i_we & addr_is(i_addr, `OFS_IRQ_STATUS);
    wire wr_irq_msk = i_we & addr_is(i_addr, `OFS_IRQ_MASK);
    wire wr_div     = i_we & addr_is(i_addr, `OFS_TICK_DIV);

    wire rd_ctrl    = addr_is(i_addr, `OFS_CTRL);
    wire rd_expire  = addr_is(i_addr, `OFS_EXPIRE);
    wire rd_count   = addr_is(i_addr, `OFS_COUNT);
    wire rd_status  = addr_is(i_addr, `OFS_STATUS);
    wire rd_irq_st  = addr_is(i_addr, `OFS_IRQ_STATUS);
    wire rd_irq_msk = addr_is(i_addr, `OFS_IRQ_MASK);
    wire rd_div     = addr_is(i_addr, `OFS_TICK_DIV);

    // Control fields carried by a write
    wire w_enable   = i_wdata[`CTRL_EN_BIT];
    wire w_src      = i_wdata[`CTRL_SRC_BIT];
    wire w_tamp_en  = i_wdata[`CTRL_TAMP_BIT];

    // Derived status
    wire enabled    = (state_r != ST_DISABLED);
    wire counting   = (state_r == ST_COUNTING);
    wire expired    = (state_r == ST_EXPIRED);
    wire at_limit   = reached(count_r, expire_r);
    wire step       = src_bus.step;

    wire do_enable  = wr_ctrl & w_enable & ~enabled;
    wire do_disable = wr_ctrl & ~w_enable & enabled;
    wire do_defer   = wr_defer & enabled;
    wire do_reload  = wr_expire & enabled;
    wire hit        = counting & at_limit & ~do_defer & ~do_reload & ~do_disable;
    wire tamp_now   = enabled & tamp_en_r & i_tamper;
    wire tamp_event = tamp_now & ~tamper_r;

    // Next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_DISABLED: begin
                if (do_enable) begin
                    state_nxt = ST_COUNTING;
                end
            end
            ST_COUNTING: begin
                if (do_disable) begin
                    state_nxt = ST_DISABLED;
                end else if (hit) begin
                    state_nxt = ST_EXPIRED;
                end
            end
            ST_EXPIRED: begin
                if (do_disable) begin
                    state_nxt = ST_DISABLED;
                end else if (do_defer | do_reload) begin
                    state_nxt = ST_COUNTING;
                end
            end
            default: begin
                state_nxt = ST_DISABLED;
            end
        endcase
        if (i_init) begin
            state_nxt = `DEF_ENABLE ? ST_COUNTING : ST_DISABLED;
        end
    end

    // Count: restarts on enable or deferral, freezes at expiry
    always_comb begin
        count_nxt = count_r;
        if (i_init) begin
            count_nxt = `ZERO_COUNT;
        end else if (do_enable | do_defer) begin
            count_nxt = `ZERO_COUNT;
        end else if (counting & step & ~at_limit & ~do_disable) begin
            count_nxt = count_r + `ONE_COUNT;
        end
    end

    // Expiry value writable in any state
    always_comb begin
        expire_nxt = expire_r;
        if (i_init) begin
            expire_nxt = `DEF_EXPIRE;
        end else if (wr_expire) begin
            expire_nxt = i_wdata;
        end
    end

    // Source and divider frozen while enabled, so software
    // cannot stretch a running count by swapping its source
    always_comb begin
        src_sel_nxt = src_sel_r;
        tamp_en_nxt = tamp_en_r;
        div_nxt     = div_r;
        if (i_init) begin
            src_sel_nxt = SRC_TICK;
            tamp_en_nxt = `DEF_TAMP_EN;
            div_nxt     = `DEF_DIV;
        end else if (~enabled) begin
            if (wr_ctrl) begin
                src_sel_nxt = w_src ? SRC_EVENT : SRC_TICK;
                tamp_en_nxt = w_tamp_en;
            end
            if (wr_div) begin
                div_nxt = i_wdata[`WDG_DIV_W-1:0];
            end
        end
    end

    // Tamper latch holds attention until initialize or disable
    always_comb begin
        tamper_nxt = tamper_r;
        if (i_init | do_disable) begin
            tamper_nxt = 1'b0;
        end else if (tamp_now) begin
            tamper_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_r <= ST_DISABLED;
            count_r <= `ZERO_COUNT;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            expire_r  <= `DEF_EXPIRE;
            src_sel_r <= SRC_TICK;
            tamp_en_r <= `DEF_TAMP_EN;
            div_r     <= `DEF_DIV;
            tamper_r  <= 1'b0;
        end else begin
            expire_r  <= expire_nxt;
            src_sel_r <= src_sel_nxt;
            tamp_en_r <= tamp_en_nxt;
            div_r     <= div_nxt;
            tamper_r  <= tamper_nxt;
        end
    end

    // Count source
    assign src_bus.div     = div_r;
    assign src_bus.sel     = src_sel_r;
    assign src_bus.run     = counting;
    assign src_bus.restart = i_init | do_enable | do_defer;

    count_source u_source (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_event  (i_event),
        .src      (src_bus.src)
    );

    // Attention: gated by enable in every term
    assign o_attention = enabled & (expired | tamper_r | tamp_now);

    // Interrupts
    logic [`WDG_IRQ_W-1:0] irq_set;
    logic [`WDG_IRQ_W-1:0] irq_clr;
    logic [`WDG_IRQ_W-1:0] irq_status;
    logic [`WDG_IRQ_W-1:0] irq_mask;

    always_comb begin
        irq_set                = `ZERO_IRQ;
        irq_set[`IRQ_EXP_BIT]  = hit;
        irq_set[`IRQ_TAMP_BIT] = tamp_event;
        irq_set[`IRQ_INIT_BIT] = i_init;
    end

    assign irq_clr = wr_irq_st ? i_wdata[`WDG_IRQ_W-1:0] : `ZERO_IRQ;

    sticky_irq u_irq (
        .i_clk        (i_clk),
        .i_resetn     (i_resetn),
        .i_set        (irq_set),
        .i_clr        (irq_clr),
        .i_mask_we    (wr_irq_msk),
        .i_mask_wdata (i_wdata[`WDG_IRQ_W-1:0]),
        .o_status     (irq_status),
        .o_mask       (irq_mask),
        .o_irq        (o_irq)
    );

    // Readback of all visible state
    logic [`WDG_DATA_W-1:0] ctrl_word;
    logic [`WDG_DATA_W-1:0] status_word;

    always_comb begin
        ctrl_word                  = `ZERO_WORD;
        ctrl_word[`CTRL_EN_BIT]    = enabled;
        ctrl_word[`CTRL_SRC_BIT]   = (src_sel_r == SRC_EVENT);
        ctrl_word[`CTRL_TAMP_BIT]  = tamp_en_r;
    end

    always_comb begin
        status_word                 = `ZERO_WORD;
        status_word[`STAT_EN_BIT]   = enabled;
        status_word[`STAT_ATTN_BIT] = o_attention;
        status_word[`STAT_TAMP_BIT] = tamper_r;
        status_word[`STAT_STATE_MSB:`STAT_STATE_LSB] = state_r;
    end

    always_comb begin
        rdata_nxt = `ZERO_WORD;
        if (i_re) begin
            if (rd_ctrl) begin
                rdata_nxt = ctrl_word;
            end else if (rd_expire) begin
                rdata_nxt = expire_r;
            end else if (rd_count) begin
                rdata_nxt = count_r;
            end else if (rd_status) begin
                rdata_nxt = status_word;
            end else if (rd_irq_st) begin
                rdata_nxt[`WDG_IRQ_W-1:0] = irq_status;
            end else if (rd_irq_msk) begin
                rdata_nxt[`WDG_IRQ_W-1:0] = irq_mask;
            end else if (rd_div) begin
                rdata_nxt[`WDG_DIV_W-1:0] = div_r;
            end
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rdata_r <= `ZERO_WORD;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;
endmodule
`default_nettype wire

/* File: verif/basic_watchdog_assertions.sv */
// Port-level checks for the basic watchdog.
// Assumes one clock domain; bound onto basic_watchdog.
`timescale 1ns/1ns
`default_nettype none
`include "basic_watchdog_consts.svh"
module basic_watchdog_assertions (
    input  wire logic                   i_clk,
    input  wire logic                   i_resetn,
    input  wire logic [`WDG_ADDR_W-1:0] i_addr,
    input  wire logic [`WDG_DATA_W-1:0] i_wdata,
    input  wire logic                   i_we,
    input  wire logic                   i_re,
    input  wire logic [`WDG_DATA_W-1:0] o_rdata,
    input  wire logic                   i_init,
    input  wire logic                   i_tamper,
    input  wire logic                   o_attention
);
    logic en_r;
    logic tamp_en_r;
    wire  ctrl_wr = i_we && (i_addr == `OFS_CTRL);

    // Enable as software last set it; settings frozen once enabled
    always_ff @(posedge i_clk) begin
        if (!i_resetn || i_init) begin
            en_r      <= `DEF_ENABLE;
            tamp_en_r <= `DEF_TAMP_EN;
        end else if (ctrl_wr) begin
            en_r      <= i_wdata[`CTRL_EN_BIT];
            tamp_en_r <= en_r ? tamp_en_r : i_wdata[`CTRL_TAMP_BIT];
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    sequence s_exp_write;
        i_we && !i_init && i_addr == `OFS_EXPIRE;
    endsequence
    sequence s_exp_read;
        i_re && !i_init && i_addr == `OFS_EXPIRE;
    endsequence
    sequence s_init_then_ctrl_read;
        i_init ##1 (i_re && !i_init && i_addr == `OFS_CTRL);
    endsequence

    property p_rdata_idle;
        !i_re |=> o_rdata == `ZERO_WORD;
    endproperty
    property p_defer_reads_zero;
        i_re && i_addr == `OFS_DEFER |=> o_rdata == `ZERO_WORD;
    endproperty
    property p_exp_readback;
        s_exp_write ##1 s_exp_read |=> o_rdata == $past(i_wdata, 2);
    endproperty
    property p_init_defaults;
        s_init_then_ctrl_read |=> o_rdata[2:0] == {`DEF_TAMP_EN, 1'b0, `DEF_ENABLE};
    endproperty
    property p_init_quiet;
        i_init |=> !o_attention;
    endproperty
    property p_quiet_disabled;
        !en_r |-> !o_attention;
    endproperty
    property p_tamper_fast;
        en_r && tamp_en_r && i_tamper |-> o_attention;
    endproperty
    // Tamper excluded: its attention path is combinational
    property p_attn_holds;
        o_attention && !i_we && !i_init && !i_tamper |=> o_attention;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read answer");
    a_defer_reads_zero: assert property (p_defer_reads_zero)
        else $error("defer register read not zero");
    a_exp_readback: assert property (p_exp_readback)
        else $error("expiry value not read back");
    a_init_defaults: assert property (p_init_defaults)
        else $error("control not at defaults after initialize");
    a_init_quiet: assert property (p_init_quiet)
        else $error("attention high after initialize");
    a_quiet_disabled: assert property (p_quiet_disabled)
        else $error("attention high while disabled");
    a_tamper_fast: assert property (p_tamper_fast)
        else $error("tamper did not raise attention at once");
    a_attn_holds: assert property (p_attn_holds)
        else $error("attention dropped without cause");
endmodule

bind basic_watchdog basic_watchdog_assertions chk (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
    .i_re(i_re), .o_rdata(o_rdata), .i_init(i_init), .i_tamper(i_tamper),
    .o_attention(o_attention));
`default_nettype wire

/* File: verif/recovery_model.sv */
// Recovery logic: answers a standing attention with an initialize pulse.
// Assumes the watchdog clock; i_delay sets how slowly it reacts.
`timescale 1ns/1ns
`default_nettype none
module recovery_model (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_arm,
    input  wire logic [7:0] i_delay,
    input  wire logic       i_attention,
    output var  logic       o_init
);
    logic [7:0] wait_r = 8'h00;
    initial o_init = 1'b0;
    // One-cycle pulse, then the wait restarts from zero whether or not attention has dropped
    always @(posedge i_clk) begin
        if (!i_resetn || !i_attention || o_init) begin
            wait_r <= 8'h00;
            o_init <= 1'b0;
        end else if (wait_r == i_delay) begin
            o_init <= i_arm;
        end else begin
            wait_r <= wait_r + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench: watchdog, recovery model, bound checker.
// Assumes design, package, interface and checker compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "basic_watchdog_consts.svh"
module tb_top;
    logic                   i_clk    = 1'b0;
    logic                   i_resetn = 1'b0;
    logic [`WDG_ADDR_W-1:0] i_addr   = 8'h00;
    logic [`WDG_DATA_W-1:0] i_wdata  = 32'h0;
    logic                   i_we     = 1'b0;
    logic                   i_re     = 1'b0;
    logic                   i_event  = 1'b0;
    logic                   i_tamper = 1'b0;
    logic                   arm      = 1'b0;
    wire  logic [31:0]      o_rdata;
    wire  logic             i_init;
    wire  logic             o_attention;
    wire  logic             o_irq;
    int                     fails       = 0;
    int                     checks_done = 0;
    int                     n;
    logic [31:0]            d;
    time                    we_clr_t    = 0;

    basic_watchdog dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_we(i_we), .i_re(i_re), .o_rdata(o_rdata), .i_init(i_init),
        .i_event(i_event), .i_tamper(i_tamper), .o_attention(o_attention), .o_irq(o_irq));
    recovery_model rec (.i_clk(i_clk), .i_resetn(i_resetn), .i_arm(arm), .i_delay(8'h05),
        .i_attention(o_attention), .o_init(i_init));

    initial forever #4 i_clk = ~i_clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Bus tasks start and end on a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        // Let an edge pass rather than drop and raise the strobe in one step
        if (we_clr_t == $time) begin
            @(posedge i_clk);
        end
        i_we    <= 1'b1;
        i_addr  <= a;
        i_wdata <= v;
        @(posedge i_clk);
        i_we     <= 1'b0;
        we_clr_t = $time;
    endtask
    task automatic rd(input logic [7:0] a);
        i_re   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_re <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        check(d, exp);
    endtask
    task automatic flag(input logic f, input logic exp);
        check({31'h0, f}, {31'h0, exp});
    endtask
    task automatic wait_attn();
        n = 0;
        while (o_attention !== 1'b1 && n < 200) begin
            @(posedge i_clk);
            n++;
            #1;
        end
        @(posedge i_clk);
    endtask
    task automatic pulse_ev();
        i_event <= 1'b1;
        @(posedge i_clk);
        i_event <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic t_defaults();
        rdc(`OFS_CTRL, {29'h0, `DEF_TAMP_EN, 1'b0, `DEF_ENABLE});
        rdc(`OFS_EXPIRE, `DEF_EXPIRE);
        rdc(`OFS_COUNT, `ZERO_COUNT);
        rdc(`OFS_STATUS, `ZERO_WORD);
        rdc(`OFS_TICK_DIV, {16'h0, `DEF_DIV});
        rdc(8'h20, `ZERO_WORD);
        flag(o_attention, 1'b0);
        $display("test defaults done");
    endtask
    task automatic t_tick();
        wr(`OFS_TICK_DIV, 32'h3);
        wr(`OFS_EXPIRE, 32'h3);
        wr(`OFS_CTRL, 32'h5);
        rdc(`OFS_STATUS, 32'h11);
        wait_attn();
        flag(n >= 11 && n <= 17, 1'b1);
        rdc(`OFS_STATUS, 32'h23);
        repeat (12) @(posedge i_clk);
        rdc(`OFS_COUNT, 32'h3);
        rdc(`OFS_IRQ_STATUS, 32'h1);
        flag(o_irq, 1'b0);
        wr(`OFS_IRQ_MASK, 32'h7);
        rdc(`OFS_IRQ_MASK, 32'h7);
        flag(o_irq, 1'b1);
        wr(`OFS_IRQ_STATUS, 32'h1);
        rdc(`OFS_IRQ_STATUS, 32'h0);
        flag(o_irq, 1'b0);
        $display("test tick expiry done");
    endtask
    task automatic t_defer();
        wr(`OFS_DEFER, 32'h0);
        rdc(`OFS_STATUS, 32'h11);
        // Each restart lands before the 14 cycles that expiry needs
        repeat (6) begin
            repeat (8) @(posedge i_clk);
            flag(o_attention, 1'b0);
            wr(`OFS_DEFER, 32'h0);
        end
        wr(`OFS_EXPIRE, 32'h40);
        rdc(`OFS_EXPIRE, 32'h40);
        wr(`OFS_CTRL, 32'h0);
        rdc(`OFS_STATUS, 32'h0);
        rdc(`OFS_DEFER, `ZERO_WORD);
        $display("test defer done");
    endtask
    task automatic t_event();
        wr(`OFS_CTRL, 32'h6);
        wr(`OFS_EXPIRE, 32'h2);
        rd(`OFS_COUNT);
        pulse_ev();
        pulse_ev();
        rdc(`OFS_COUNT, d);
        wr(`OFS_CTRL, 32'h7);
        repeat (40) @(posedge i_clk);
        rdc(`OFS_COUNT, 32'h0);
        pulse_ev();
        pulse_ev();
        wait_attn();
        flag(n <= 4, 1'b1);
        rdc(`OFS_COUNT, 32'h2);
        $display("test event source done");
    endtask
    task automatic t_init();
        arm <= 1'b1;
        n = 0;
        while (i_init !== 1'b1 && n < 50) begin
            @(posedge i_clk);
            n++;
            #1;
        end
        @(posedge i_clk);
        arm <= 1'b0;
        flag(n < 50, 1'b1);
        rdc(`OFS_CTRL, 32'h4);
        flag(o_attention, 1'b0);
        rdc(`OFS_EXPIRE, `DEF_EXPIRE);
        rdc(`OFS_COUNT, `ZERO_COUNT);
        rdc(`OFS_TICK_DIV, {16'h0, `DEF_DIV});
        rdc(`OFS_IRQ_STATUS, 32'h5);
        rdc(`OFS_IRQ_MASK, 32'h7);
        flag(o_irq, 1'b1);
        $display("test initialize done");
    endtask
    task automatic t_tamper();
        wr(`OFS_CTRL, 32'h5);
        i_tamper <= 1'b1;
        @(posedge i_clk);
        flag(o_attention, 1'b1);
        rd(`OFS_STATUS);
        flag(d[`STAT_TAMP_BIT], 1'b1);
        rd(`OFS_IRQ_STATUS);
        flag(d[`IRQ_TAMP_BIT], 1'b1);
        wr(`OFS_CTRL, 32'h0);
        rdc(`OFS_STATUS, 32'h0);
        flag(o_attention, 1'b0);
        i_tamper <= 1'b0;
        $display("test tamper done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge i_clk);
        i_resetn <= 1'b1;
        @(posedge i_clk);
        t_defaults();
        t_tick();
        t_defer();
        t_event();
        t_init();
        t_tamper();
        conclude();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_clk);
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
